// >>> verilog/fsq_unit_regs.vh
// Constants for the float sign and square-root unit.
// Assumes single-precision operands and a 7-bit exception flag vector.
`ifndef FSQ_UNIT_REGS_VH
`define FSQ_UNIT_REGS_VH

// Operation codes
`define FSQ_OP_SIGN 8'h98
`define FSQ_OP_SIGNFLAGS 8'h99
`define FSQ_OP_SQRT 8'h6E
`define FSQ_OP_SQRTFLAGS 8'h6F

// Flag vector bit positions
`define FSQ_FLAG_DBZ 0
`define FSQ_FLAG_INX 1
`define FSQ_FLAG_UNF 2
`define FSQ_FLAG_OVF 3
`define FSQ_FLAG_INV 4
`define FSQ_FLAG_IFZ 5
`define FSQ_FLAG_OFZ 6
`define FSQ_FLAG_W 7

// Reset values
`define FSQ_FLAGS_RST 7'h00
`define FSQ_WORD_RST 32'h00000000

// Result words
`define FSQ_ONE 32'h00000001
`define FSQ_MINUS_ONE 32'hFFFFFFFF
`define FSQ_QNAN 32'hFFFFFFFF
`define FSQ_PINF 32'h7F800000

// Rounding-mode encodings
`define FSQ_RM_NEAREST 2'h0
`define FSQ_RM_POS 2'h1
`define FSQ_RM_NEG 2'h2
`define FSQ_RM_ZERO 2'h3

// Timing in cycles of the core clock
`define FSQ_SQRT_LATENCY 5'h11
`define FSQ_SQRT_RECOVERY 5'h10
`define FSQ_SQRT_STEPS 5'h0D

`endif

// >>> verilog/fsq_unit.v
// Float sign, sign-flags, square root and square-root-flags execution unit.
// Assumes the issue logic presents one operation per slot per cycle and the
// register file writes a destination when the matching write enable is high.
//
// Operation
// RQ1 - Sign writes 0 for zero, 1 for positive, all ones for negative
// RQ2 - Sign treats denormal operand as zero, returns 0, sets input-flushed flag
// RQ3 - Sign uses code 152, one operand, latency one, slot three only
// RQ4 - Sign-flags uses code 153, one operand, latency one, slot three only
// RQ5 - Square root uses code 110, latency 17, recovery 16, slot two only
// RQ6 - Status flags are sticky; only an explicit status write clears them
// RQ7 - Status flags update in the cycle the destination is written
// RQ8 - Simultaneous flag updates are ORed together and with current flags
// RQ9 - Guard bit zero blocks destination and flag updates; one allows both
// RQ10 - Sign-flags writes the sign's flag vector, leaves status flags alone
// RQ11 - Flag vector: dbz0 inx1 unf2 ovf3 inv4 ifz5 ofz6, upper bits zero
// RQ12 - Sign-flags on denormal computes as zero and reports input-flushed bit
// RQ13 - Sign of NaN returns 0 and raises invalid; sign-flags reports invalid
// RQ14 - Square root rounds by the status-word rounding mode
// RQ15 - Square root substitutes zero for denormal input, sets input-flushed
// RQ16 - Denormal square-root result becomes zero with output-flushed flag
// RQ17 - Square root of negative operand gives quiet NaN and invalid
// RQ18 - Square root of positive infinity is positive infinity, no flags
// RQ19 - Sign of negative infinity or negative normal is minus one, no flag
// RQ20 - Square root sets inexact when rounded result differs from exact root
// RQ21 - Square-root-flags shares layout and timing, leaves status flags alone

`timescale 1ns/1ps
`include "fsq_unit_regs.vh"

module fsq_unit
(
  input wire clk,
  input wire rst,
  input wire cmp_issue,
  input wire [7:0] cmp_opcode,
  input wire [31:0] cmp_source_register,
  input wire [31:0] cmp_guard,
  input wire [6:0] cmp_dest,
  input wire tough_issue,
  input wire [7:0] tough_opcode,
  input wire [31:0] tough_source_register,
  input wire [31:0] tough_guard,
  input wire [6:0] tough_dest,
  input wire [1:0] round_mode,
  input wire ext_flags_valid,
  input wire [6:0] ext_flags,
  input wire status_wr,
  input wire [6:0] status_wr_flags,
  output reg cmp_wr_en,
  output reg [6:0] cmp_wr_dest,
  output reg [31:0] cmp_wr_data,
  output reg tough_wr_en,
  output reg [6:0] tough_wr_dest,
  output reg [31:0] tough_wr_data,
  output reg tough_busy,
  output reg [6:0] program_status_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Compare-unit decode: sign and sign-flags, one cycle

  wire [7:0] cmp_exp;
  wire [22:0] cmp_frac;
  wire cmp_is_zero;
  wire cmp_is_denorm;
  wire cmp_is_nan;
  wire cmp_op_sign;
  wire cmp_op_flags;
  wire cmp_take;
  wire [31:0] sign_value;
  wire [6:0] sign_flags;

  assign cmp_exp = cmp_source_register[30:23];
  assign cmp_frac = cmp_source_register[22:0];
  assign cmp_is_zero = (cmp_exp == 8'h00);
  assign cmp_is_denorm = cmp_is_zero && (cmp_frac != 23'h000000);
  assign cmp_is_nan = (cmp_exp == 8'hFF) && (cmp_frac != 23'h000000);
  assign cmp_op_sign = (cmp_opcode == `FSQ_OP_SIGN); // RQ3
  assign cmp_op_flags = (cmp_opcode == `FSQ_OP_SIGNFLAGS); // RQ4
  // Guard false drops the operation entirely
  assign cmp_take = cmp_issue && cmp_guard[0] && (cmp_op_sign || cmp_op_flags); // RQ9

  // Zero, flushed denormals and NaNs all answer 0; infinities keep their sign
  assign sign_value = (cmp_is_zero || cmp_is_nan) ? `FSQ_WORD_RST : // RQ1 RQ13
    (cmp_source_register[31] ? `FSQ_MINUS_ONE : `FSQ_ONE); // RQ1 RQ19
  assign sign_flags = ({6'h00, cmp_is_denorm} << `FSQ_FLAG_IFZ) | // RQ2 RQ12
    ({6'h00, cmp_is_nan} << `FSQ_FLAG_INV); // RQ13

  ////////////////////////////////////////////////////////////////////////////
  // Long-latency unit: issue, special cases, operand preparation

  wire [7:0] sq_exp;
  wire [22:0] sq_frac;
  wire sq_sign;
  wire sq_op_root;
  wire sq_op_flags;
  wire sq_accept;
  wire [8:0] sq_exp_sum;
  reg sq_special;
  reg [31:0] sq_special_value;
  reg [6:0] sq_special_flags;

  assign sq_exp = tough_source_register[30:23];
  assign sq_frac = tough_source_register[22:0];
  assign sq_sign = tough_source_register[31];
  assign sq_op_root = (tough_opcode == `FSQ_OP_SQRT); // RQ5
  assign sq_op_flags = (tough_opcode == `FSQ_OP_SQRTFLAGS); // RQ21
  // A new issue inside the recovery window is ignored
  assign sq_accept = tough_issue && !tough_busy && (sq_op_root || sq_op_flags); // RQ5
  assign sq_exp_sum = {1'b0, sq_exp} + 9'h07F;

  always @*
  begin
    sq_special = 1'b1;
    sq_special_value = `FSQ_WORD_RST;
    sq_special_flags = `FSQ_FLAGS_RST;
    if (sq_exp == 8'h00)
    begin
      // Zero and flushed denormals keep their sign, as the root of a signed zero
      sq_special_value = {sq_sign, 31'h00000000};
      if (sq_frac != 23'h000000)
      begin
        sq_special_flags[`FSQ_FLAG_IFZ] = 1'b1; // RQ15
      end
    end
    else if (sq_exp == 8'hFF && sq_frac != 23'h000000)
    begin
      sq_special_value = `FSQ_QNAN;
      // Only a signalling NaN raises invalid
      sq_special_flags[`FSQ_FLAG_INV] = !sq_frac[22];
    end
    else if (sq_sign)
    begin
      sq_special_value = `FSQ_QNAN; // RQ17
      sq_special_flags[`FSQ_FLAG_INV] = 1'b1; // RQ17
    end
    else if (sq_exp == 8'hFF)
    begin
      sq_special_value = `FSQ_PINF; // RQ18
    end
    else
    begin
      sq_special = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Long-latency unit: two root bits per cycle

  reg [4:0] sq_cnt_r;
  wire [4:0] sq_cnt_nxt;
  reg [51:0] sq_rad_r;
  reg [27:0] sq_rem_r;
  reg [25:0] sq_root_r;
  reg [7:0] sq_rexp_r;
  reg [1:0] sq_rm_r;
  reg sq_special_r;
  reg [31:0] sq_sval_r;
  reg [6:0] sq_sflags_r;
  reg sq_guard_r;
  reg sq_is_flags_r;
  reg [6:0] sq_dest_r;
  reg [27:0] step_rem;
  reg [25:0] step_root;
  reg [51:0] step_rad;
  reg [27:0] step_trial;
  integer i;

  always @*
  begin
    step_rem = sq_rem_r;
    step_root = sq_root_r;
    step_rad = sq_rad_r;
    step_trial = 28'h0000000;
    for (i = 0; i < 2; i = i + 1)
    begin
      step_rem = {step_rem[25:0], step_rad[51:50]};
      step_rad = {step_rad[49:0], 2'b00};
      step_trial = {step_root[25:0], 2'b01};
      if (step_rem >= step_trial)
      begin
        step_rem = step_rem - step_trial;
        step_root = {step_root[24:0], 1'b1};
      end
      else
      begin
        step_root = {step_root[24:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Long-latency unit: rounding and flag vector

  wire sq_guard_bit;
  wire sq_sticky;
  wire sq_inexact;
  reg sq_round_up;
  wire [24:0] sq_mant_rnd;
  wire [7:0] sq_exp_rnd;
  reg [31:0] sq_value;
  reg [6:0] sq_flags;

  assign sq_guard_bit = sq_root_r[1];
  assign sq_sticky = sq_root_r[0] || (sq_rem_r != 28'h0000000);
  assign sq_inexact = sq_guard_bit || sq_sticky; // RQ20

  always @*
  begin
    case (sq_rm_r) // RQ14
      `FSQ_RM_NEAREST: sq_round_up = sq_guard_bit && (sq_sticky || sq_root_r[2]);
      `FSQ_RM_POS: sq_round_up = sq_inexact;
      `FSQ_RM_NEG: sq_round_up = 1'b0;
      `FSQ_RM_ZERO: sq_round_up = 1'b0;
      default: sq_round_up = 1'b0;
    endcase
  end

  assign sq_mant_rnd = {1'b0, sq_root_r[25:2]} + {24'h000000, sq_round_up};
  // Carry out of the mantissa bumps the exponent by one
  assign sq_exp_rnd = sq_rexp_r + {7'h00, sq_mant_rnd[24]};

  always @*
  begin
    sq_value = `FSQ_WORD_RST;
    sq_flags = `FSQ_FLAGS_RST;
    if (sq_special_r)
    begin
      sq_value = sq_sval_r;
      sq_flags = sq_sflags_r;
    end
    else if (sq_exp_rnd == 8'h00)
    begin
      // A normal input keeps the root exponent at 64 or above, so this flush is only a safeguard
      sq_flags[`FSQ_FLAG_OFZ] = 1'b1; // RQ16
    end
    else
    begin
      sq_value = {1'b0, sq_exp_rnd, sq_mant_rnd[22:0]};
      sq_flags[`FSQ_FLAG_INX] = sq_inexact; // RQ20
    end
  end

  assign sq_cnt_nxt = sq_accept ? (`FSQ_SQRT_LATENCY - 5'h01) : // RQ5
    ((sq_cnt_r != 5'h00) ? (sq_cnt_r - 5'h01) : sq_cnt_r);

  always @(posedge clk)
  begin
    if (rst)
    begin
      sq_cnt_r <= 5'h00;
      tough_busy <= 1'b0;
      sq_rad_r <= 52'h0000000000000;
      sq_rem_r <= 28'h0000000;
      sq_root_r <= 26'h0000000;
      sq_rexp_r <= 8'h00;
      sq_rm_r <= `FSQ_RM_NEAREST;
      sq_special_r <= 1'b0;
      sq_sval_r <= `FSQ_WORD_RST;
      sq_sflags_r <= `FSQ_FLAGS_RST;
      sq_guard_r <= 1'b0;
      sq_is_flags_r <= 1'b0;
      sq_dest_r <= 7'h00;
    end
    else
    begin
      sq_cnt_r <= sq_cnt_nxt;
      // Busy covers the recovery window; the last latency cycle may reissue
      tough_busy <= (sq_cnt_nxt > (`FSQ_SQRT_LATENCY - `FSQ_SQRT_RECOVERY)); // RQ5
      if (sq_accept)
      begin
        // Odd unbiased exponent needs one more radicand shift to stay even
        if (sq_exp[0])
        begin
          sq_rad_r <= {1'b0, 1'b1, sq_frac, 27'h0000000};
        end
        else
        begin
          sq_rad_r <= {1'b1, sq_frac, 28'h0000000};
        end
        sq_rem_r <= 28'h0000000;
        sq_root_r <= 26'h0000000;
        sq_rexp_r <= sq_exp_sum[8:1];
        sq_rm_r <= round_mode; // RQ14
        sq_special_r <= sq_special;
        sq_sval_r <= sq_special_value;
        sq_sflags_r <= sq_special_flags;
        sq_guard_r <= tough_guard[0];
        sq_is_flags_r <= sq_op_flags;
        sq_dest_r <= tough_dest;
      end
      else if (sq_cnt_r > (`FSQ_SQRT_LATENCY - `FSQ_SQRT_STEPS - 5'h01))
      begin
        sq_rad_r <= step_rad;
        sq_rem_r <= step_rem;
        sq_root_r <= step_root;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-back and sticky status flags

  wire sq_done;
  wire sq_write;
  reg [6:0] flags_nxt;

  assign sq_done = (sq_cnt_r == 5'h01);
  assign sq_write = sq_done && sq_guard_r; // RQ9

  always @*
  begin
    // A clear and a set in one cycle: the set wins
    flags_nxt = status_wr ? status_wr_flags : program_status_word; // RQ6
    if (cmp_take && cmp_op_sign)
    begin
      flags_nxt = flags_nxt | sign_flags; // RQ8
    end
    if (sq_write && !sq_is_flags_r)
    begin
      flags_nxt = flags_nxt | sq_flags; // RQ8
    end
    if (ext_flags_valid)
    begin
      flags_nxt = flags_nxt | ext_flags; // RQ8
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cmp_wr_en <= 1'b0;
      cmp_wr_dest <= 7'h00;
      cmp_wr_data <= `FSQ_WORD_RST;
      tough_wr_en <= 1'b0;
      tough_wr_dest <= 7'h00;
      tough_wr_data <= `FSQ_WORD_RST;
      program_status_word <= `FSQ_FLAGS_RST;
    end
    else
    begin
      // Flags load on the same edge as the destination write strobe
      program_status_word <= flags_nxt; // RQ7
      cmp_wr_en <= cmp_take; // RQ3
      cmp_wr_dest <= cmp_dest;
      if (cmp_take)
      begin
        cmp_wr_data <= cmp_op_flags ? {25'h0000000, sign_flags} : sign_value; // RQ1 RQ10
      end
      tough_wr_en <= sq_write; // RQ5
      tough_wr_dest <= sq_dest_r;
      if (sq_write)
      begin
        tough_wr_data <= sq_is_flags_r ? {25'h0000000, sq_flags} : sq_value; // RQ11 RQ14
      end
    end
  end

endmodule

// >>> tb/fsq_unit_props.sv
// Concurrent checks for the float sign and square-root unit.
// Assumes it is bound to fsq_unit and sees only that module's ports.
`timescale 1ns/1ps
`include "fsq_unit_regs.vh"
module fsq_unit_props
(
  input logic clk,
  input logic rst,
  input logic cmp_issue,
  input logic [7:0] cmp_opcode,
  input logic [31:0] cmp_source_register,
  input logic [31:0] cmp_guard,
  input logic tough_issue,
  input logic [7:0] tough_opcode,
  input logic [31:0] tough_guard,
  input logic ext_flags_valid,
  input logic status_wr,
  input logic cmp_wr_en,
  input logic [31:0] cmp_wr_data,
  input logic tough_wr_en,
  input logic tough_busy,
  input logic [6:0] program_status_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [7:0] sexp = cmp_source_register[30:23];
  wire sg_take = cmp_issue && cmp_guard[0] &&
    (cmp_opcode == `FSQ_OP_SIGN || cmp_opcode == `FSQ_OP_SIGNFLAGS);
  wire sg_sign = sg_take && cmp_opcode == `FSQ_OP_SIGN;
  wire rt_take = tough_issue && !tough_busy &&
    (tough_opcode == `FSQ_OP_SQRT || tough_opcode == `FSQ_OP_SQRTFLAGS);
  //////////////////////////////////////////////////////////////////////////////
  chk_sign_answer: assert property (sg_take |=> cmp_wr_en)
    else $error("sign op not answered after one cycle");
  chk_guard_drop: assert property (cmp_issue && !cmp_guard[0] |=> !cmp_wr_en)
    else $error("guarded-off sign op wrote");
  chk_sign_neg: assert property (sg_sign && cmp_source_register[31] && sexp != 8'h00
    && sexp != 8'hFF |=> cmp_wr_data == 32'hFFFFFFFF)
    else $error("negative operand did not give minus one");
  chk_sign_flush: assert property (sg_sign && sexp == 8'h00
    && cmp_source_register[22:0] != 23'h000000 |=> cmp_wr_data == 32'h0 && program_status_word[5])
    else $error("denormal sign not flushed");
  chk_vec_upper: assert property (cmp_wr_en && $past(cmp_opcode) == `FSQ_OP_SIGNFLAGS
    |-> cmp_wr_data[31:7] == 25'h0000000)
    else $error("flag vector upper bits set");
  chk_flags_sticky: assert property (!status_wr |=> (program_status_word
    & $past(program_status_word)) == $past(program_status_word))
    else $error("sticky flag lost");
  chk_flags_moment: assert property ($changed(program_status_word) |-> cmp_wr_en
    || tough_wr_en || $past(ext_flags_valid) || $past(status_wr))
    else $error("flags changed without a write");
  chk_root_latency: assert property (rt_take && tough_guard[0] |-> ##17 tough_wr_en)
    else $error("root result not at 17 cycles");
  chk_root_guard: assert property (rt_take && !tough_guard[0] |-> ##17 !tough_wr_en)
    else $error("guarded-off root wrote");
  chk_busy_span: assert property (rt_take |=> tough_busy[*8] ##1 tough_busy[*7]
    ##1 !tough_busy)
    else $error("recovery window wrong");
  cover property (sg_sign && sexp == 8'h00);
  cover property (rt_take ##17 tough_wr_en);
  cover property (sg_sign && ext_flags_valid && status_wr);
endmodule
bind fsq_unit fsq_unit_props u_props (.clk(clk), .rst(rst), .cmp_issue(cmp_issue),
  .cmp_opcode(cmp_opcode), .cmp_source_register(cmp_source_register),
  .cmp_guard(cmp_guard), .tough_issue(tough_issue), .tough_opcode(tough_opcode),
  .tough_guard(tough_guard), .ext_flags_valid(ext_flags_valid), .status_wr(status_wr),
  .cmp_wr_en(cmp_wr_en), .cmp_wr_data(cmp_wr_data), .tough_wr_en(tough_wr_en),
  .tough_busy(tough_busy), .program_status_word(program_status_word));

// >>> tb/fsq_regfile.sv
// Register file model on the far side of both write ports.
// Assumes the two ports never hit one index in the same cycle.
`timescale 1ns/1ps
module fsq_regfile
(
  input logic clk,
  input logic a_en,
  input logic [6:0] a_dest,
  input logic [31:0] a_data,
  input logic b_en,
  input logic [6:0] b_dest,
  input logic [31:0] b_data
);
  logic [31:0] mem [0:127];
  // Known fill so an unwanted write is visible
  initial for (int i = 0; i < 128; i++) mem[i] = 32'h5A5A5A5A;
  always @(posedge clk)
  begin
    if (a_en) mem[a_dest] <= a_data;
    if (b_en) mem[b_dest] <= b_data;
  end
endmodule

// >>> tb/fsq_unit_tb.sv
// Self-checking bench for the float sign and square-root unit.
// Assumes the checker is bound in and the register file model is compiled.
`timescale 1ns/1ps
module fsq_unit_tb;
  typedef struct packed {logic [1:0] rm; logic [7:0] op; logic [31:0] src;
    logic [31:0] res; logic [6:0] flg;} fsq_row_t;
  fsq_row_t rows [0:20];
  logic clk = 0, rst = 1, cmp_issue = 0, tough_issue = 0, ext_flags_valid = 0, status_wr = 0;
  logic [7:0] cmp_opcode = 0, tough_opcode = 0;
  logic [31:0] cmp_source_register = 0, cmp_guard = 0, tough_source_register = 0;
  logic [31:0] tough_guard = 0;
  logic [6:0] cmp_dest = 0, tough_dest = 0, ext_flags = 0, status_wr_flags = 0;
  logic [1:0] round_mode = 0;
  wire cmp_wr_en, tough_wr_en, tough_busy;
  wire [6:0] cmp_wr_dest, tough_wr_dest, program_status_word;
  wire [31:0] cmp_wr_data, tough_wr_data;
  int mismatches = 0, checked = 0, pulses = 0;
  fsq_unit DUT (.clk(clk), .rst(rst), .cmp_issue(cmp_issue), .cmp_opcode(cmp_opcode),
    .cmp_source_register(cmp_source_register), .cmp_guard(cmp_guard), .cmp_dest(cmp_dest),
    .tough_issue(tough_issue), .tough_opcode(tough_opcode), .tough_guard(tough_guard),
    .tough_source_register(tough_source_register), .tough_dest(tough_dest),
    .round_mode(round_mode), .ext_flags_valid(ext_flags_valid), .ext_flags(ext_flags),
    .status_wr(status_wr), .status_wr_flags(status_wr_flags), .cmp_wr_en(cmp_wr_en),
    .cmp_wr_dest(cmp_wr_dest), .cmp_wr_data(cmp_wr_data), .tough_wr_en(tough_wr_en),
    .tough_wr_dest(tough_wr_dest), .tough_wr_data(tough_wr_data), .tough_busy(tough_busy),
    .program_status_word(program_status_word));
  fsq_regfile rf (.clk(clk), .a_en(cmp_wr_en), .a_dest(cmp_wr_dest), .a_data(cmp_wr_data),
    .b_en(tough_wr_en), .b_dest(tough_wr_dest), .b_data(tough_wr_data));
  always #25 clk = ~clk;
  always @(posedge clk) if (tough_wr_en) pulses++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      checked++;
      if (got !== exp)
      begin
        mismatches++;
        $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Issue on the slot picked by the top opcode bit, then drop the request
  task automatic iss(input [7:0] op, input [31:0] src, input [31:0] g, input [6:0] d);
    begin
      @(posedge clk);
      if (op[7])
        {cmp_issue, cmp_opcode, cmp_source_register, cmp_guard, cmp_dest} <= {1'b1, op, src, g, d};
      else
        {tough_issue, tough_opcode, tough_source_register, tough_guard, tough_dest} <=
          {1'b1, op, src, g, d};
      @(posedge clk);
      cmp_issue <= 1'b0;
      tough_issue <= 1'b0;
    end
  endtask
  task automatic set_flags(input [6:0] f);
    begin
      @(posedge clk);
      status_wr <= 1'b1;
      status_wr_flags <= f;
      @(posedge clk);
      status_wr <= 1'b0;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(3000 * 50);
    mismatches++;
    print_verdict;
  end
  initial
  begin
    int n;
    logic [31:0] res;
    rows = '{
      '{2'h0, 8'h98, 32'h40400000, 32'h00000001, 7'h00},
      '{2'h0, 8'h98, 32'hBF800000, 32'hFFFFFFFF, 7'h00},
      '{2'h0, 8'h98, 32'h80800000, 32'hFFFFFFFF, 7'h00},
      '{2'h0, 8'h98, 32'hFF800000, 32'hFFFFFFFF, 7'h00},
      '{2'h0, 8'h98, 32'h00000000, 32'h00000000, 7'h00},
      '{2'h0, 8'h98, 32'h80400000, 32'h00000000, 7'h20},
      '{2'h0, 8'h98, 32'hFFFFFFFF, 32'h00000000, 7'h10},
      '{2'h0, 8'h99, 32'h80400000, 32'h00000020, 7'h00},
      '{2'h0, 8'h99, 32'h7FFFFFFF, 32'h00000010, 7'h00},
      '{2'h0, 8'h99, 32'hBF800000, 32'h00000000, 7'h00},
      '{2'h0, 8'h6E, 32'hC0400000, 32'hFFFFFFFF, 7'h10},
      '{2'h0, 8'h6E, 32'h40400000, 32'h3FDDB3D7, 7'h02},
      '{2'h1, 8'h6E, 32'h40400000, 32'h3FDDB3D8, 7'h02},
      '{2'h2, 8'h6E, 32'h40400000, 32'h3FDDB3D7, 7'h02},
      '{2'h3, 8'h6E, 32'h40400000, 32'h3FDDB3D7, 7'h02},
      '{2'h0, 8'h6E, 32'h00C00000, 32'h201CC471, 7'h02},
      '{2'h0, 8'h6E, 32'h7F800000, 32'h7F800000, 7'h00},
      '{2'h0, 8'h6E, 32'h7F7FFFFF, 32'h5F7FFFFF, 7'h02},
      '{2'h0, 8'h6E, 32'h00400000, 32'h00000000, 7'h20},
      '{2'h0, 8'h6F, 32'hC0400000, 32'h00000010, 7'h00},
      '{2'h0, 8'h6F, 32'h40400000, 32'h00000002, 7'h00}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 21; i++)
    begin
      set_flags(7'h00);
      round_mode <= rows[i].rm;
      iss(rows[i].op, rows[i].src, 32'h1, i[6:0]);
      n = 1;
      #1;
      while (!(cmp_wr_en || tough_wr_en) && n < 40)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(n, rows[i].op[7] ? 1 : 17, "latency");
      res = rows[i].op[7] ? cmp_wr_data : tough_wr_data;
      chk(res, rows[i].res, "result");
      chk({25'h0, (rows[i].op[7] ? cmp_wr_dest : tough_wr_dest)}, i, "dest");
      chk({25'h0, program_status_word}, {25'h0, rows[i].flg}, "flags");
    end
    $display("table test done");
    set_flags(7'h00);
    iss(8'h98, 32'hFFFFFFFF, 32'hFFFFFFFE, 7'd100);
    iss(8'h6E, 32'hC0400000, 32'hFFFFFFFE, 7'd101);
    repeat (20) @(posedge clk);
    #1;
    chk(pulses, 21 - 10, "guarded root pulses");
    chk(rf.mem[100], 32'h5A5A5A5A, "guarded sign dest");
    chk(rf.mem[101], 32'h5A5A5A5A, "guarded root dest");
    chk({25'h0, program_status_word}, 32'h0, "guarded flags");
    $display("guard test done");
    // Sign, another unit and a status write all land on one edge; the sets must win
    @(posedge clk);
    {cmp_issue, cmp_opcode, cmp_source_register, cmp_guard, cmp_dest} <=
      {1'b1, 8'h98, 32'hFFFFFFFF, 32'h1, 7'd102};
    {ext_flags_valid, ext_flags, status_wr, status_wr_flags} <= {1'b1, 7'h08, 1'b1, 7'h04};
    @(posedge clk);
    {cmp_issue, ext_flags_valid, status_wr} <= 3'h0;
    #1;
    chk({25'h0, program_status_word}, 32'h1C, "ored flags");
    iss(8'h98, 32'h3F800000, 32'h1, 7'd103);
    #1;
    chk({25'h0, program_status_word}, 32'h1C, "sticky flags");
    set_flags(7'h01);
    #1;
    chk({25'h0, program_status_word}, 32'h01, "explicit write");
    $display("flag test done");
    pulses = 0;
    iss(8'h6E, 32'h40400000, 32'h1, 7'd104);
    repeat (4) @(posedge clk);
    iss(8'h6E, 32'h00C00000, 32'h1, 7'd105);
    repeat (8) @(posedge clk);
    iss(8'h6F, 32'h40400000, 32'h1, 7'd106);
    repeat (20) @(posedge clk);
    #1;
    chk(pulses, 2, "root pulses");
    chk(rf.mem[105], 32'h5A5A5A5A, "dropped root");
    chk(rf.mem[106], 32'h2, "root at recovery edge");
    $display("recovery test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({25'h0, program_status_word}, 32'h0, "reset flags");
    chk({tough_busy, cmp_wr_en, tough_wr_en}, 32'h0, "reset strobes");
    $display("reset test done");
    print_verdict;
  end
endmodule
